// *** rtl/rtcc_pkg.sv ***
// Constants, register map and helpers shared by the calendar and control block.
package rtcc_pkg;

	// Low-speed source rate in Hz and the one-second period of the tick.
	localparam int unsigned LS_CLK_HZ = 32768;
	localparam int unsigned TICK_PERIOD_S = 1;
	localparam int unsigned LS_DIV = LS_CLK_HZ * TICK_PERIOD_S;

	// Register byte addresses on the register bus.
	localparam logic [7:0] OFS_SEC   = 8'h00;
	localparam logic [7:0] OFS_MIN   = 8'h04;
	localparam logic [7:0] OFS_HOUR  = 8'h08;
	localparam logic [7:0] OFS_MONTH = 8'h0c;
	localparam logic [7:0] OFS_YEAR  = 8'h10;
	localparam logic [7:0] OFS_BANK  = 8'h14;
	localparam logic [7:0] OFS_STS   = 8'h18;
	localparam logic [7:0] OFS_MSK   = 8'h1c;

	// Bank control field positions.
	localparam int BIT_IRQ_EN = 7;
	localparam int BIT_ADJ    = 4;
	localparam int BIT_CNT_EN = 3;
	localparam int BIT_ALM_EN = 2;
	localparam int BIT_PAGE   = 0;

	// Event status bit positions and width.
	localparam int STS_TICK = 0;
	localparam int STS_ADJ  = 1;
	localparam int STS_MIN  = 2;
	localparam int STS_W    = 3;

	// BCD limits.
	localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
	localparam logic [6:0] SEC_MAX       = 7'h59;
	localparam logic [6:0] SEC_HALF      = 7'h30;
	localparam logic [6:0] MIN_MAX       = 7'h59;
	localparam logic [5:0] HOUR24_MAX    = 6'h23;
	localparam logic [4:0] HOUR12_MAX    = 5'h11;
	localparam int         HOUR_PM_BIT   = 5;

	// Bus responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	function automatic logic [7:0] rtcc_bcd_inc(input logic [7:0] v);
		if (v[3:0] == BCD_DIGIT_MAX)
			return {v[7:4] + 4'h1, 4'h0};
		else
			return {v[7:4], v[3:0] + 4'h1};
	endfunction

endpackage

// *** rtl/rtcc_tick_if.sv ***
// One-second tick carried from the prescaler to the register block.
`timescale 1ns/1ps
`default_nettype none
interface rtcc_tick_if;
	logic sec_tick;
	modport src (output sec_tick);
	modport snk (input sec_tick);
endinterface
`default_nettype wire

// *** rtl/rtcc_prescaler.sv ***
// Second counter dividing low-speed clock edges down to a one-second tick.
`timescale 1ns/1ps
`default_nettype none
module rtcc_prescaler
	import rtcc_pkg::*;
#(
	parameter int unsigned DIV = LS_DIV
)
(
	input  wire logic  core_clk_i,
	input  wire logic  rst_i,
	input  wire logic  ls_tick_i,
	rtcc_tick_if.src   tick_o
);
	localparam int CW = $clog2(DIV);

	typedef struct packed
	{
		logic [CW-1:0] cnt;
		logic          tick;
	} rtcc_pre_state_t;

	rtcc_pre_state_t r;
	rtcc_pre_state_t next_r;

	// The divider keeps running while counting is disabled, so the tick phase is kept.
	always_comb
	begin
		next_r = r;
		next_r.tick = 1'b0;
		if (ls_tick_i)
		begin
			if (r.cnt == CW'(DIV - 1))
			begin
				next_r.cnt = '0;
				next_r.tick = 1'b1;
			end
			else
				next_r.cnt = r.cnt + CW'(1);
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			r <= '0;
		else
			r <= next_r;
	end

	assign tick_o.sec_tick = r.tick;

	AST_TICK_FROM_LS: assert property (@(posedge core_clk_i) disable iff (rst_i)
		r.tick |-> $past(ls_tick_i) && $past(r.cnt) == CW'(DIV - 1))
		else $error("Second tick without a full low-speed count.");

endmodule
`default_nettype wire

// *** rtl/rtcc_top.sv ***
// Calendar, hour format, leap phase and bank control registers of the real-time clock.
//
// Function
// - Page 0 month address holds 5-bit BCD month 01..12; upper bits read zero.
// - Page 1 month address holds hour format bit 0; other bits read zero.
// - Page 0 year address holds an 8-bit BCD year 00..99.
// - Page 1 year address holds 2-bit leap phase; other bits read zero.
// - An second_round_request request is acted on only at the next second tick.
// - Second_round_request with seconds 0..29 clears seconds, minutes untouched.
// - Second_round_request with seconds 30..59 clears seconds and carries into minutes.
// - Second_round_request bit reads one while pending; writing zero does nothing.
// - Control bits: 7 interrupt enable, 3 count, 2 alarm, 0 page; 6,5,1 zero.
// - In 12-hour format hour bit 5 marks PM, hours 0..11 in BCD.
// - A one-second tick is divided down from the low-speed clock.
`timescale 1ns/1ps
`default_nettype none
module rtcc_top
	import rtcc_pkg::*;
#(
	parameter int unsigned DIV = LS_DIV
)
(
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic        ls_tick_i,
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	output logic             clock_irq_o,
	output logic             count_en_o,
	output logic             alarm_en_o,
	output logic             bank_sel_o
);

	typedef struct packed
	{
		logic [6:0]       sec;
		logic [6:0]       min;
		logic [5:0]       hour;
		logic [4:0]       month_field;
		logic             hour_format_bit;
		logic [7:0]       year_field;
		logic [1:0]       leap;
		logic             irq_enable_bit;
		logic             second_round_request;
		logic             count_enable_bit;
		logic             alarm_en;
		logic             page;
		logic [STS_W-1:0] sts;
		logic [STS_W-1:0] msk;
		logic             aw_full;
		logic [7:0]       aw_addr;
		logic             w_full;
		logic [7:0]       w_data;
		logic             w_lane0;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             rvalid;
		logic [7:0]       rdata;
		logic [1:0]       rresp;
	} rtcc_state_t;

	rtcc_state_t r;
	rtcc_state_t next_r;
	rtcc_tick_if tick_bus ();

	logic       tick;
	logic       do_wr;
	logic       rd_take;
	logic       min_carry;
	logic       adj_done;
	logic       rd_hit;
	logic [7:0] rd_val;

	rtcc_prescaler #(
		.DIV (DIV)
	) u_prescaler (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.ls_tick_i  (ls_tick_i),
		.tick_o     (tick_bus.src)
	);

	assign tick = tick_bus.sec_tick;
	assign do_wr = r.aw_full && r.w_full && !r.bvalid;
	assign rd_take = s_axi_arvalid_i && !r.rvalid;

	// Read decode; page-dependent addresses show only the fields of the selected page.
	always_comb
	begin
		rd_hit = 1'b1;
		rd_val = 8'h00;
		unique case (s_axi_araddr_i)
			OFS_SEC:
				rd_val = {1'b0, r.sec};
			OFS_MIN:
				rd_val = {1'b0, r.min};
			OFS_HOUR:
				rd_val = {2'h0, r.hour};
			OFS_MONTH:
				if (r.page)
					rd_val = {7'h00, r.hour_format_bit};
				else
					rd_val = {3'h0, r.month_field};
			OFS_YEAR:
				if (r.page)
					rd_val = {6'h00, r.leap};
				else
					rd_val = r.year_field;
			OFS_BANK:
			begin
				rd_val[BIT_IRQ_EN] = r.irq_enable_bit;
				rd_val[BIT_ADJ]    = r.second_round_request;
				rd_val[BIT_CNT_EN] = r.count_enable_bit;
				rd_val[BIT_ALM_EN] = r.alarm_en;
				rd_val[BIT_PAGE]   = r.page;
			end
			OFS_STS:
				rd_val = {{(8 - STS_W){1'b0}}, r.sts};
			OFS_MSK:
				rd_val = {{(8 - STS_W){1'b0}}, r.msk};
			default:
				rd_hit = 1'b0;
		endcase
	end

	always_comb
	begin
		next_r = r;
		min_carry = 1'b0;
		adj_done = 1'b0;

		// Timekeeping at the second tick; the divider itself never stops.
		if (tick)
		begin
			if (r.second_round_request)
			begin
				// Second_round_request takes the place of the normal count for this tick.
				next_r.second_round_request = 1'b0;
				next_r.sec = '0;
				min_carry = (r.sec >= SEC_HALF);
				adj_done = 1'b1;
			end
			else if (r.count_enable_bit)
			begin
				if (r.sec == SEC_MAX)
				begin
					next_r.sec = '0;
					min_carry = 1'b1;
				end
				else
					next_r.sec = 7'(rtcc_bcd_inc({1'b0, r.sec}));
			end
		end

		if (min_carry)
		begin
			if (r.min == MIN_MAX)
			begin
				next_r.min = '0;
				if (r.hour_format_bit)
				begin
					if (r.hour == HOUR24_MAX)
						next_r.hour = '0;
					else
						next_r.hour = 6'(rtcc_bcd_inc({2'h0, r.hour}));
				end
				else if (r.hour[4:0] == HOUR12_MAX)
					next_r.hour = {~r.hour[HOUR_PM_BIT], 5'h00};
				else
					next_r.hour = {r.hour[HOUR_PM_BIT], 5'(rtcc_bcd_inc({3'h0, r.hour[4:0]}))};
			end
			else
				next_r.min = 7'(rtcc_bcd_inc({1'b0, r.min}));
		end

		// Write address and data are taken independently, in either order.
		if (s_axi_awvalid_i && !r.aw_full)
		begin
			next_r.aw_full = 1'b1;
			next_r.aw_addr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && !r.w_full)
		begin
			next_r.w_full = 1'b1;
			next_r.w_data = s_axi_wdata_i[7:0];
			next_r.w_lane0 = s_axi_wstrb_i[0];
		end
		if (r.bvalid && s_axi_bready_i)
			next_r.bvalid = 1'b0;

		// A software write to a time field overrides the tick update of the same cycle.
		if (do_wr)
		begin
			next_r.aw_full = 1'b0;
			next_r.w_full = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp = RESP_OKAY;
			unique case (r.aw_addr)
				OFS_SEC:
					if (r.w_lane0)
						next_r.sec = r.w_data[6:0];
				OFS_MIN:
					if (r.w_lane0)
						next_r.min = r.w_data[6:0];
				OFS_HOUR:
					if (r.w_lane0)
						next_r.hour = r.w_data[5:0];
				OFS_MONTH:
					if (r.w_lane0)
					begin
						if (r.page)
							next_r.hour_format_bit = r.w_data[0];
						else
							next_r.month_field = r.w_data[4:0];
					end
				OFS_YEAR:
					if (r.w_lane0)
					begin
						if (r.page)
							next_r.leap = r.w_data[1:0];
						else
							next_r.year_field = r.w_data;
					end
				OFS_BANK:
					if (r.w_lane0)
					begin
						next_r.irq_enable_bit = r.w_data[BIT_IRQ_EN];
						next_r.count_enable_bit = r.w_data[BIT_CNT_EN];
						next_r.alarm_en = r.w_data[BIT_ALM_EN];
						next_r.page = r.w_data[BIT_PAGE];
						// A one raises the request; a zero is ignored, and a new request beats the tick.
						if (r.w_data[BIT_ADJ])
							next_r.second_round_request = 1'b1;
					end
				OFS_STS:
					if (r.w_lane0)
						next_r.sts = r.sts & ~r.w_data[STS_W-1:0];
				OFS_MSK:
					if (r.w_lane0)
						next_r.msk = r.w_data[STS_W-1:0];
				default:
					next_r.bresp = RESP_SLVERR;
			endcase
		end

		// Events are applied after the write-one-to-clear, so a set in the same cycle wins.
		if (tick)
			next_r.sts[STS_TICK] = 1'b1;
		if (adj_done)
			next_r.sts[STS_ADJ] = 1'b1;
		if (min_carry)
			next_r.sts[STS_MIN] = 1'b1;

		// Reads answer one cycle after the address is taken.
		if (r.rvalid && s_axi_rready_i)
			next_r.rvalid = 1'b0;
		if (rd_take)
		begin
			next_r.rvalid = 1'b1;
			next_r.rdata = rd_val;
			next_r.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// Calendar fields carry no defined reset value in use; clearing them keeps simulation free of X.
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			r <= '0;
		else
			r <= next_r;
	end

	assign s_axi_awready_o = !r.aw_full;
	assign s_axi_wready_o = !r.w_full;
	assign s_axi_bvalid_o = r.bvalid;
	assign s_axi_bresp_o = r.bresp;
	assign s_axi_arready_o = !r.rvalid;
	assign s_axi_rvalid_o = r.rvalid;
	assign s_axi_rdata_o = {24'h000000, r.rdata};
	assign s_axi_rresp_o = r.rresp;
	assign clock_irq_o = r.irq_enable_bit && |(r.sts & r.msk);
	assign count_en_o = r.count_enable_bit;
	assign alarm_en_o = r.alarm_en;
	assign bank_sel_o = r.page;

	AST_RESET_CONTROL: assert property (@(posedge core_clk_i)
		rst_i |=> !r.irq_enable_bit && !r.second_round_request && !r.page && !clock_irq_o)
		else $error("Control bits not cleared by reset.");

	AST_ADJ_WAITS_TICK: assert property (@(posedge core_clk_i) disable iff (rst_i)
		r.second_round_request && !tick |=> r.second_round_request)
		else $error("Second_round_request request left before a second tick.");

	AST_ADJ_LOW_CLEAR: assert property (@(posedge core_clk_i) disable iff (rst_i)
		tick && r.second_round_request && r.sec < SEC_HALF && !do_wr
		|=> r.sec == 7'h00 && r.min == $past(r.min))
		else $error("Low second_round_request did not clear seconds or touched minutes.");

	AST_ADJ_HIGH_CARRY: assert property (@(posedge core_clk_i) disable iff (rst_i)
		tick && r.second_round_request && r.sec >= SEC_HALF && !do_wr
		|=> r.sec == 7'h00 && r.min != $past(r.min) && r.sts[STS_MIN])
		else $error("High second_round_request did not carry into minutes.");

	AST_ADJ_READBACK: assert property (@(posedge core_clk_i) disable iff (rst_i)
		rd_take && s_axi_araddr_i == OFS_BANK
		|=> s_axi_rvalid_o && s_axi_rdata_o[BIT_ADJ] == $past(r.second_round_request))
		else $error("Second_round_request read-back does not show the pending state.");

	AST_ADJ_WRITE_ZERO: assert property (@(posedge core_clk_i) disable iff (rst_i)
		do_wr && r.aw_addr == OFS_BANK && !r.w_data[BIT_ADJ] && !r.second_round_request
		|=> !r.second_round_request)
		else $error("Writing zero raised an second_round_request request.");

	AST_BANK_RESERVED: assert property (@(posedge core_clk_i) disable iff (rst_i)
		rd_take && s_axi_araddr_i == OFS_BANK
		|=> s_axi_rdata_o[6:5] == 2'h0 && !s_axi_rdata_o[1] && s_axi_rdata_o[BIT_PAGE] == $past(r.page))
		else $error("Control register reserved bits or page read wrong.");

	AST_MONTH_PAGE: assert property (@(posedge core_clk_i) disable iff (rst_i)
		rd_take && s_axi_araddr_i == OFS_MONTH
		|=> $past(r.page) ? s_axi_rdata_o[7:1] == 7'h00 : s_axi_rdata_o[7:5] == 3'h0)
		else $error("Month address shows bits outside its page field.");

	AST_YEAR_PAGE1: assert property (@(posedge core_clk_i) disable iff (rst_i)
		rd_take && s_axi_araddr_i == OFS_YEAR && r.page |=> s_axi_rdata_o[7:2] == 6'h00)
		else $error("Leap phase read shows upper bits.");

	AST_HOUR12_PM: assert property (@(posedge core_clk_i) disable iff (rst_i)
		tick && r.count_enable_bit && !r.second_round_request && !do_wr && !r.hour_format_bit
		&& r.sec == SEC_MAX && r.min == MIN_MAX && r.hour[4:0] == HOUR12_MAX
		|=> r.hour[4:0] == 5'h00 && r.hour[HOUR_PM_BIT] != $past(r.hour[HOUR_PM_BIT]))
		else $error("Twelve-hour wrap did not toggle the PM bit.");

	AST_WRITE_RESP: assert property (@(posedge core_clk_i) disable iff (rst_i)
		do_wr || (s_axi_bvalid_o && !s_axi_bready_i) |=> s_axi_bvalid_o)
		else $error("Write response not raised, or dropped before it was taken.");

endmodule
`default_nettype wire

// *** testbench/rtcc_top_bench.sv ***
// Self-checking bench for the calendar, format, leap phase and control registers.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("unexpected at %0t: got %h, expected %h", $time, (g), (e)); end end
module rtcc_top_bench
	import rtcc_pkg::*;
;
	// A short divider keeps each simulated second to a handful of low-speed pulses.
	localparam int unsigned SIM_DIV = 4;

	logic        core_clk;
	logic        rst;
	logic        ls_tick;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        irq;
	logic        cnt_en;
	logic        alm_en;
	logic        bank;
	int          n_fail;
	int          checks_done;
	logic [7:0]  adj_sec [4] = '{8'h00, 8'h29, 8'h30, 8'h59};
	logic [7:0]  adj_min [4] = '{8'h10, 8'h10, 8'h11, 8'h11};

	rtcc_top #(.DIV(SIM_DIV)) i_rtcc_top (
		.core_clk_i      (core_clk),
		.rst_i           (rst),
		.ls_tick_i       (ls_tick),
		.s_axi_awaddr_i  (awaddr),
		.s_axi_awvalid_i (awvalid),
		.s_axi_awready_o (awready),
		.s_axi_wdata_i   (wdata),
		.s_axi_wstrb_i   (4'hf),
		.s_axi_wvalid_i  (wvalid),
		.s_axi_wready_o  (wready),
		.s_axi_bresp_o   (bresp),
		.s_axi_bvalid_o  (bvalid),
		.s_axi_bready_i  (1'b1),
		.s_axi_araddr_i  (araddr),
		.s_axi_arvalid_i (arvalid),
		.s_axi_arready_o (arready),
		.s_axi_rdata_o   (rdata),
		.s_axi_rresp_o   (rresp),
		.s_axi_rvalid_o  (rvalid),
		.s_axi_rready_i  (1'b1),
		.clock_irq_o     (irq),
		.count_en_o      (cnt_en),
		.alarm_en_o      (alm_en),
		.bank_sel_o      (bank)
	);

	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic summarize;
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic give_up;
		n_fail++;
		$display("unexpected at %0t: bus wait timed out", $time);
		summarize();
	endtask

	// Response ready is held high for the whole run, so the answer is taken at the edge it is seen.
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
		int n;
		n = 0;
		awaddr  <= a;
		wdata   <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		do
		begin
			@(posedge core_clk);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end
		while (!bvalid && n < 100);
		if (!bvalid)
			give_up();
		else
			`CHK(bresp, er)
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
		int n;
		n = 0;
		araddr  <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge core_clk);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
		end
		while (!rvalid && n < 100);
		if (!rvalid)
			give_up();
		else
		begin
			`CHK(rdata, {24'h0, d})
			`CHK(rresp, er)
		end
	endtask

	task automatic pulse_ls(input int n);
		repeat (n)
		begin
			@(posedge core_clk);
			ls_tick <= 1'b1;
			@(posedge core_clk);
			ls_tick <= 1'b0;
		end
		repeat (3) @(posedge core_clk);
	endtask

	initial
	begin
		n_fail = 0;
		checks_done = 0;
		rst = 1'b1;
		ls_tick = 1'b0;
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0;
		wvalid = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rd(OFS_BANK, 8'h00);
		`CHK(irq, 1'b0)
		wr(OFS_MONTH, 8'h12);
		rd(OFS_MONTH, 8'h12);
		wr(OFS_YEAR, 8'h99);
		rd(OFS_YEAR, 8'h99);
		wr(OFS_BANK, 8'h01);
		`CHK(bank, 1'b1)
		wr(OFS_MONTH, 8'h01);
		rd(OFS_MONTH, 8'h01);
		for (int i = 0; i < 4; i++)
		begin
			wr(OFS_YEAR, 8'(i));
			rd(OFS_YEAR, 8'(i));
		end
		wr(OFS_MONTH, 8'h00);
		wr(OFS_BANK, 8'h00);
		rd(OFS_MONTH, 8'h12);
		rd(OFS_YEAR, 8'h99);
		// Reserved control bits are set here on purpose; they must read back as zero.
		wr(OFS_BANK, 8'h6e);
		rd(OFS_BANK, 8'h0c);
		`CHK({cnt_en, alm_en}, 2'b11)
		wr(OFS_BANK, 8'h00);
		wr(OFS_HOUR, 8'h11);
		wr(OFS_MIN, 8'h59);
		wr(OFS_SEC, 8'h59);
		wr(OFS_BANK, 8'h08);
		pulse_ls(SIM_DIV);
		rd(OFS_SEC, 8'h00);
		rd(OFS_MIN, 8'h00);
		rd(OFS_HOUR, 8'h20);
		wr(OFS_BANK, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			wr(OFS_SEC, adj_sec[i]);
			wr(OFS_MIN, 8'h10);
			wr(OFS_BANK, 8'h10);
			rd(OFS_BANK, 8'h10);
			wr(OFS_BANK, 8'h00);
			rd(OFS_BANK, 8'h10);
			rd(OFS_SEC, adj_sec[i]);
			pulse_ls(SIM_DIV);
			rd(OFS_SEC, 8'h00);
			rd(OFS_MIN, adj_min[i]);
			rd(OFS_BANK, 8'h00);
		end
		// The 24-hour wrap needs the format bit set; it is set here while the clock is stopped.
		wr(OFS_BANK, 8'h01);
		wr(OFS_MONTH, 8'h01);
		wr(OFS_BANK, 8'h00);
		wr(OFS_HOUR, 8'h23);
		wr(OFS_MIN, 8'h59);
		wr(OFS_SEC, 8'h59);
		wr(OFS_BANK, 8'h08);
		pulse_ls(SIM_DIV);
		rd(OFS_HOUR, 8'h00);
		rd(OFS_MIN, 8'h00);
		wr(OFS_STS, 8'h07);
		rd(OFS_STS, 8'h00);
		wr(OFS_MSK, 8'h01);
		rd(OFS_MSK, 8'h01);
		wr(OFS_BANK, 8'h08);
		wr(OFS_BANK, 8'h88);
		`CHK(irq, 1'b0)
		pulse_ls(SIM_DIV - 1);
		rd(OFS_STS, 8'h00);
		pulse_ls(1);
		rd(OFS_STS, 8'h01);
		`CHK(irq, 1'b1)
		wr(OFS_MSK, 8'h00);
		`CHK(irq, 1'b0)
		wr(OFS_MSK, 8'h01);
		`CHK(irq, 1'b1)
		wr(OFS_STS, 8'h01);
		`CHK(irq, 1'b0)
		wr(OFS_BANK, 8'h08);
		pulse_ls(SIM_DIV);
		`CHK(irq, 1'b0)
		rd(OFS_SEC, 8'h02);
		// A reset in mid-run must drop a pending second_round_request and the page select.
		wr(OFS_BANK, 8'h11);
		rd(OFS_BANK, 8'h11);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rd(OFS_BANK, 8'h00);
		`CHK(bank, 1'b0)
		wr(8'h20, 8'h55, RESP_SLVERR);
		rd(8'h20, 8'h00, RESP_SLVERR);
		summarize();
	end
endmodule
`default_nettype wire
